// ===== core/dsc_map.svh
/*
 * Constants of the double speed clock and bus strobe block: field positions,
 * reset values and cycle counts.
 * Assumes it is included by bare name from the package only; the design modules use its macros without including it.
 */
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

`define DSC_X2_BIT          0
`define DSC_X2_RESET        1'h0
`define DSC_LATCH_OFF_BIT   0
`define DSC_STD_CLKS        12
`define DSC_X2_CLKS         6
`define DSC_GAP_W           4
`define DSC_INT_CODE_TOP    16'h3FFF
`define DSC_EA_RESET        1'h1
`define DSC_SYNC_RESET      3'h2

`endif

// ===== core/dsc_pkg.sv
/*
 * Types of the double speed clock and bus strobe block.
 * Assumes dsc_map.svh is on the include path.
 */
package dsc_pkg;
    `include "dsc_map.svh"

    // six states per machine cycle, one bit changing per step except S6 back to S1
    typedef enum logic [2:0] {
        DSC_S1 = 3'h0,
        DSC_S2 = 3'h1,
        DSC_S3 = 3'h3,
        DSC_S4 = 3'h2,
        DSC_S5 = 3'h6,
        DSC_S6 = 3'h7
    } dsc_phase_type;

    typedef struct packed {
        logic                  div_q;
        logic                  x2_q;
        dsc_phase_type         ph_q;
        logic [`DSC_GAP_W-1:0] gap_q;
        logic                  steady_q;
    } dsc_gen_type;

    typedef struct packed {
        logic [2:0] ea_sync_q;
        logic       ea_latched_q;
        logic       ea_caught_q;
        logic       movx_q;
        logic       ale_q;
        logic       program_fetch_strobe_n_q;
        logic       ext_fetch_q;
        logic       periph_tick_q;
    } dsc_strobe_type;
endpackage : dsc_pkg

// ===== core/dsc_if.sv
/*
 * Carrier between the phase generator and the strobe logic.
 * Assumes both ends run on the same crystal clock.
 */
`timescale 1ns/10ps
interface dsc_if;
    import dsc_pkg::*;
    logic          x2_req;
    logic          x2_active;
    logic          tick;
    logic          mc_end;
    dsc_phase_type phase;

    modport gen  (input x2_req, output x2_active, output tick, output mc_end, output phase);
    modport user (output x2_req, input x2_active, input tick, input mc_end, input phase);
endinterface : dsc_if

// ===== core/dsc_phase_gen.sv
/*
 * Divide-by-two stage, speed mode latch and six-state phase generator.
 * Assumes clk is the crystal clock and rst_n is already synchronised.
 */
`timescale 1ns/10ps
module dsc_phase_gen
    import dsc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    dsc_if.gen        gi
);
    dsc_gen_type s_q;
    dsc_gen_type s_d;
    logic        tick;

    function automatic dsc_phase_type next_phase(input dsc_phase_type p);
        case (p)
            DSC_S1:  next_phase = DSC_S2;
            DSC_S2:  next_phase = DSC_S3;
            DSC_S3:  next_phase = DSC_S4;
            DSC_S4:  next_phase = DSC_S5;
            DSC_S5:  next_phase = DSC_S6;
            DSC_S6:  next_phase = DSC_S1;
            default: next_phase = DSC_S1;
        endcase
    endfunction : next_phase

    // bypassed divider in double speed, halved rate otherwise
    assign tick = s_q.x2_q | s_q.div_q;

    always_comb begin
        s_d       = s_q;
        s_d.div_q = ~s_q.div_q;
        // mode taken only when the halved clock rises; on leaving double speed the first standard state lasts one clock
        if (!s_q.div_q) begin
            s_d.x2_q = gi.x2_req;
        end
        if (tick) begin
            s_d.ph_q = next_phase(s_q.ph_q);
        end
        // helper for checking: clocks since the last cycle end, mode unchanged
        if (tick && s_q.ph_q == DSC_S6) begin
            s_d.gap_q    = '0;
            s_d.steady_q = 1'b1;
        end else begin
            s_d.gap_q = s_q.gap_q + `DSC_GAP_W'(1);
            if (s_d.x2_q != s_q.x2_q) begin
                s_d.steady_q = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{div_q: 1'b0, x2_q: `DSC_X2_RESET, ph_q: DSC_S1,
                     gap_q: '0, steady_q: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign gi.x2_active = s_q.x2_q;
    assign gi.tick      = tick;
    assign gi.phase     = s_q.ph_q;
    assign gi.mc_end    = tick && s_q.ph_q == DSC_S6;

    AST_STD_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
        gi.mc_end && s_q.steady_q && !s_q.x2_q |-> s_q.gap_q == `DSC_GAP_W'(`DSC_STD_CLKS - 1))
        else $error("standard machine cycle is not 12 clocks");

    AST_X2_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
        gi.mc_end && s_q.steady_q && s_q.x2_q |-> s_q.gap_q == `DSC_GAP_W'(`DSC_X2_CLKS - 1))
        else $error("double speed machine cycle is not 6 clocks");

    AST_SWITCH_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(s_q.x2_q) |-> s_q.div_q && !$past(s_q.div_q))
        else $error("speed mode changed off the halved clock rising edge");

    AST_HALF_RATE: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !s_q.x2_q |=> !tick)
        else $error("phase ticks back to back in standard mode");
endmodule : dsc_phase_gen

// ===== core/dsc_clock_top.sv
/*
 * Double speed core clock with the external memory strobes.
 * Assumes clk is the crystal clock; the core supplies the speed select,
 * latch suppress, program counter and external data access request as
 * same-clock levels; the external access select pin is asynchronous.
 */
`timescale 1ns/10ps
module dsc_clock_top
    import dsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        double_speed_select,
    input  wire logic        latch_suppress,
    input  wire logic        ext_data_access,
    input  wire logic [15:0] program_counter,
    input  wire logic        external_access_select,
    input  wire logic        security_level1,
    output logic             address_latch_strobe,
    output logic             program_fetch_strobe_n,
    output logic             external_fetch,
    output logic             core_phase_tick,
    output logic             periph_tick,
    output logic             x2_active
);
    logic           rst_meta_q;
    logic           rst_q;
    dsc_strobe_type s_q;
    dsc_strobe_type s_d;
    logic           ea_level;
    logic           ext_d;
    logic           ale_phase;
    logic           program_fetch_strobe_phase;

    dsc_if gi ();

    // release of reset through two flops, assertion stays asynchronous
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    assign gi.x2_req = double_speed_select;

    dsc_phase_gen u_gen (
        .clk   (clk),
        .rst_n (rst_q),
        .gi    (gi.gen)
    );

    // strobes sit in fixed states of the machine cycle
    function automatic logic is_ale_phase(input dsc_phase_type p);
        is_ale_phase = (p == DSC_S1) || (p == DSC_S4);
    endfunction : is_ale_phase

    function automatic logic is_program_fetch_strobe_phase(input dsc_phase_type p);
        is_program_fetch_strobe_phase = (p == DSC_S2) || (p == DSC_S5);
    endfunction : is_program_fetch_strobe_phase

    assign ale_phase  = is_ale_phase(gi.phase);
    assign program_fetch_strobe_phase = is_program_fetch_strobe_phase(gi.phase);

    // pin agrees on stages two and three; stage one feeds stage two only
    // stages reset to disagree, so nothing is caught before the pin has filled stage two
    assign ea_level = (security_level1 && s_q.ea_caught_q) ? s_q.ea_latched_q
                                                          : s_q.ea_sync_q[2];

    // low select means external from 0000H; relies on the board for ROMless parts
    assign ext_d = !ea_level || (program_counter > `DSC_INT_CODE_TOP);

    always_comb begin
        s_d           = s_q;
        s_d.ea_sync_q = {s_q.ea_sync_q[1:0], external_access_select};
        if (!s_q.ea_caught_q && (s_q.ea_sync_q[1] == s_q.ea_sync_q[2])) begin
            s_d.ea_latched_q = s_q.ea_sync_q[2];
            s_d.ea_caught_q  = 1'b1;
        end
        s_d.ext_fetch_q = ext_d;
        // data access request applies to the following machine cycle
        if (gi.mc_end) begin
            s_d.movx_q = ext_data_access;
        end
        // peripherals count machine cycles, so their rate follows the speed
        s_d.periph_tick_q = gi.mc_end;
        // latch pulse: two per cycle, first dropped on a data access cycle
        s_d.ale_q = ale_phase
                  && !(s_q.movx_q && gi.phase == DSC_S1)
                  && !(latch_suppress && !ext_d && !s_q.movx_q);
        // fetch strobe: external code only, both dropped on a data access
        s_d.program_fetch_strobe_n_q = !(program_fetch_strobe_phase && ext_d && !s_q.movx_q);
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            s_q <= '{ea_sync_q: `DSC_SYNC_RESET, ea_latched_q: `DSC_EA_RESET,
                     ea_caught_q: 1'b0, movx_q: 1'b0, ale_q: 1'b0, program_fetch_strobe_n_q: 1'b1,
                     ext_fetch_q: 1'b0, periph_tick_q: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign address_latch_strobe   = s_q.ale_q;
    assign program_fetch_strobe_n = s_q.program_fetch_strobe_n_q;
    assign external_fetch         = s_q.ext_fetch_q;
    assign periph_tick            = s_q.periph_tick_q;
    assign core_phase_tick        = gi.tick;
    assign x2_active              = gi.x2_active;

    AST_NO_PROGRAM_FETCH_STROBE_INTERNAL: assert property (@(posedge clk) disable iff (!rst_q)
        !program_fetch_strobe_n |-> $past(ext_d))
        else $error("fetch strobe active on an internal fetch");

    AST_PROGRAM_FETCH_STROBE_MOVX_SKIP: assert property (@(posedge clk) disable iff (!rst_q)
        $past(s_q.movx_q) |-> program_fetch_strobe_n)
        else $error("fetch strobe active during a data access cycle");

    AST_ALE_SUPPRESS: assert property (@(posedge clk) disable iff (!rst_q)
        $past(latch_suppress && !ext_d && !s_q.movx_q) |-> !address_latch_strobe)
        else $error("latch strobe active while suppressed");

    AST_ALE_MOVX_ONE: assert property (@(posedge clk) disable iff (!rst_q)
        address_latch_strobe && $past(s_q.movx_q) |-> $past(gi.phase) == DSC_S4)
        else $error("wrong latch pulse omitted on a data access");

    AST_ALE_PHASE: assert property (@(posedge clk) disable iff (!rst_q)
        $past(gi.tick && gi.phase == DSC_S6 && !latch_suppress && !ext_data_access)
        |-> ##[0:2] address_latch_strobe)
        else $error("latch strobe missing at start of machine cycle");

    AST_PERIPH_TICK: assert property (@(posedge clk) disable iff (!rst_q)
        periph_tick |-> $past(gi.phase) == DSC_S6 && $past(gi.tick) ##1 !periph_tick)
        else $error("peripheral tick not tied to machine cycle end");

    AST_EA_HOLD: assert property (@(posedge clk) disable iff (!rst_q)
        s_q.ea_caught_q |=> $stable(s_q.ea_latched_q))
        else $error("latched access select changed after capture");
endmodule : dsc_clock_top

// ===== sim/dsc_ext_mem_model.sv
/*
 * External code memory and address latch seen from the strobe pins.
 * Assumes strobes are registered on the rising crystal clock edge.
 */
`timescale 1ns/10ps
module dsc_ext_mem_model (
    input  wire logic clk,
    input  wire logic want_external,
    input  wire logic address_latch_strobe,
    input  wire logic program_fetch_strobe_n,
    output logic      external_access_select,
    output int        latch_count,
    output int        fetch_count
);
    logic ale_prev;
    logic program_fetch_strobe_prev;

    // pin held low for as long as external code is wanted
    assign external_access_select = ~want_external;

    initial begin
        latch_count = 0;
        fetch_count = 0;
        ale_prev = 1'b0;
        program_fetch_strobe_prev = 1'b1;
    end

    // latch captures on each strobe rise, memory reads on each fetch fall
    always @(posedge clk) begin
        if (address_latch_strobe === 1'b1 && ale_prev !== 1'b1) latch_count <= latch_count + 1;
        if (program_fetch_strobe_n === 1'b0 && program_fetch_strobe_prev !== 1'b0) fetch_count <= fetch_count + 1;
        ale_prev <= address_latch_strobe;
        program_fetch_strobe_prev <= program_fetch_strobe_n;
    end
endmodule : dsc_ext_mem_model

// ===== sim/test_double_speed_clock_and_bus_strobes.sv
/*
 * Self-checking bench of the double speed clock and bus strobe block.
 * Assumes the design and the external memory model are compiled first.
 */
`timescale 1ns/10ps
module test_double_speed_clock_and_bus_strobes;
    logic        clk, reset_n, double_speed_select, latch_suppress, ext_data_access;
    logic [15:0] program_counter;
    logic        security_level1, want_external, external_access_select, x2;
    logic        address_latch_strobe, program_fetch_strobe_n, external_fetch;
    logic        core_phase_tick, periph_tick, x2_active;
    logic [31:0] rng = 32'h000032CF;
    int          latch_count, fetch_count, c, l, f, p;
    int          phase_count = 0;
    int          tick_count = 0, clk_count = 0, err_count = 0, check_count = 0;

    dsc_clock_top dut_u (.clk(clk), .reset_n(reset_n),
        .double_speed_select(double_speed_select), .latch_suppress(latch_suppress),
        .ext_data_access(ext_data_access), .program_counter(program_counter),
        .external_access_select(external_access_select), .security_level1(security_level1),
        .address_latch_strobe(address_latch_strobe),
        .program_fetch_strobe_n(program_fetch_strobe_n), .external_fetch(external_fetch),
        .core_phase_tick(core_phase_tick), .periph_tick(periph_tick), .x2_active(x2_active));

    dsc_ext_mem_model mem_u (.clk(clk), .want_external(want_external),
        .address_latch_strobe(address_latch_strobe),
        .program_fetch_strobe_n(program_fetch_strobe_n),
        .external_access_select(external_access_select),
        .latch_count(latch_count), .fetch_count(fetch_count));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        clk_count <= clk_count + 1;
        if (periph_tick === 1'b1) tick_count <= tick_count + 1;
        if (core_phase_tick === 1'b1) phase_count <= phase_count + 1;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic int exp_clks(input logic m);
        return m ? 6 : 12;
    endfunction : exp_clks

    function automatic logic exp_ext(input logic sel, input logic [15:0] pc);
        return !sel || pc > 16'h3FFF;
    endfunction : exp_ext

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            err_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : cmp_cnt

    // hangs here are cut short by the watchdog
    task automatic wait_ticks(input int n);
        int t0;
        t0 = tick_count;
        while (tick_count < t0 + n) @(negedge clk);
    endtask : wait_ticks

    // four whole machine cycles, the second one optionally a data access
    task automatic measure(input logic dax);
        int c0, l0, f0, p0;
        wait_ticks(1);
        c0 = clk_count;
        p0 = phase_count;
        l0 = latch_count;
        f0 = fetch_count;
        ext_data_access = dax;
        wait_ticks(1);
        ext_data_access = 1'b0;
        wait_ticks(3);
        c = clk_count - c0;
        l = latch_count - l0;
        f = fetch_count - f0;
        p = phase_count - p0;
    endtask : measure

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : do_reset

    initial begin
        #100000;
        err_count++;
        end_of_test();
    end

    initial begin
        {double_speed_select, latch_suppress, ext_data_access, security_level1} = 4'h0;
        program_counter = 16'h0000;
        want_external = 1'b1;
        do_reset();
        cmp_bit(x2_active, 1'b0);
        for (int i = 0; i < 3; i++) begin
            x2 = (i == 1);
            double_speed_select = x2;
            repeat (3) @(negedge clk);
            cmp_bit(x2_active, x2);
            for (int d = 0; d < 2; d++) begin
                measure(d[0]);
                cmp_cnt(c, 4 * exp_clks(x2));
                cmp_cnt(p, 24);
                cmp_cnt(l, 8 - d);
                cmp_cnt(f, 8 - 2 * d);
            end
        end
        want_external = 1'b0;
        for (int k = 0; k < 2; k++) begin
            rng = xorshift(rng);
            latch_suppress = k[0];
            program_counter = {2'h0, rng[13:0]};
            repeat (6) @(negedge clk);
            cmp_bit(external_fetch, 1'b0);
            measure(1'b0);
            cmp_cnt(f, 0);
            cmp_cnt(l, k ? 0 : 8);
        end
        latch_suppress = 1'b0;
        for (int k = 0; k < 12; k++) begin
            rng = xorshift(rng);
            program_counter = (k == 0) ? 16'h3FFF : (k == 1) ? 16'h4000 : rng[15:0];
            want_external = (k < 2) ? 1'b0 : rng[16];
            repeat (6) @(negedge clk);
            cmp_bit(external_fetch, exp_ext(external_access_select, program_counter));
        end
        // select caught low at reset must outlive the pin going high
        security_level1 = 1'b1;
        want_external = 1'b1;
        program_counter = 16'h0000;
        do_reset();
        want_external = 1'b0;
        repeat (8) @(negedge clk);
        cmp_bit(external_fetch, 1'b1);
        security_level1 = 1'b0;
        repeat (8) @(negedge clk);
        cmp_bit(external_fetch, 1'b0);
        end_of_test();
    end
endmodule : test_double_speed_clock_and_bus_strobes
